// *** verilog/ddrcd_defines.svh ***
// Constants of the command decoder: pin widths, field positions,
// pin encodings and cycle counts. Guarded, so every user includes it.
`ifndef DDRCD_DEFINES_SVH
`define DDRCD_DEFINES_SVH

// Pin widths, bank and mode register counts
`define DDRCD_BA_W        3
`define DDRCD_ADDR_W      14
`define DDRCD_BANKS       8
`define DDRCD_MR_NUM      4

// Address field positions
`define DDRCD_A10_POS     10
`define DDRCD_A11_POS     11
`define DDRCD_A12_POS     12

// Burst field of mode register 0
`define DDRCD_MR0_BL_LSB  0
`define DDRCD_MR0_BL_MSB  1
`define DDRCD_BL_FIX8     2'h0
`define DDRCD_BL_OTF      2'h1
`define DDRCD_BL_FIX4     2'h2

// RAS#, CAS#, WE# encodings
`define DDRCD_PINS_MRS    3'h0
`define DDRCD_PINS_REF    3'h1
`define DDRCD_PINS_PRE    3'h2
`define DDRCD_PINS_ACT    3'h3
`define DDRCD_PINS_WR     3'h4
`define DDRCD_PINS_RD     3'h5
`define DDRCD_PINS_ZQ     3'h6
`define DDRCD_PINS_NOP    3'h7

// Cycle counts at 10 MHz
`define DDRCD_BL8_CYC     3'h4
`define DDRCD_BC4_CYC     3'h2
`define DDRCD_ZQINIT_CYC  10'h200
`define DDRCD_ZQOPER_CYC  10'h100
`define DDRCD_ZQCS_CYC    10'h040
`define DDRCD_TCKE_CYC    3'h3

// Reset values
`define DDRCD_MR_RST      14'h0000

`endif

// *** verilog/ddrcd_pkg.sv ***
// Types shared by both ends of the command link.
// Assumes the defines header sits on the include path.
`include "ddrcd_defines.svh"

package ddrcd_pkg;

  // Decoded command, one-hot
  typedef enum logic [15:0] {
    DDRCD_CMD_MRS  = 16'h0001,
    DDRCD_CMD_REF  = 16'h0002,
    DDRCD_CMD_SRE  = 16'h0004,
    DDRCD_CMD_EXIT = 16'h0008,
    DDRCD_CMD_PRE  = 16'h0010,
    DDRCD_CMD_PREA = 16'h0020,
    DDRCD_CMD_ACT  = 16'h0040,
    DDRCD_CMD_WR   = 16'h0080,
    DDRCD_CMD_RD   = 16'h0100,
    DDRCD_CMD_NOP  = 16'h0200,
    DDRCD_CMD_DES  = 16'h0400,
    DDRCD_CMD_PDE  = 16'h0800,
    DDRCD_CMD_ZQCL = 16'h1000,
    DDRCD_CMD_ZQCS = 16'h2000,
    DDRCD_CMD_HOLD = 16'h4000,
    DDRCD_CMD_BAD  = 16'h8000
  } ddrcd_cmd_t;

  // Device power state, one-hot
  typedef enum logic [3:0] {
    DDRCD_ST_IDLE = 4'h1,
    DDRCD_ST_ACT  = 4'h2,
    DDRCD_ST_PDN  = 4'h4,
    DDRCD_ST_SREF = 4'h8
  } ddrcd_state_t;

  typedef struct packed {
    ddrcd_state_t                                st;
    logic                                        cke_prev;
    ddrcd_cmd_t                                  cmd;
    logic                                        cmd_vld;
    logic [`DDRCD_BA_W-1:0]                      ba;
    logic [`DDRCD_ADDR_W-1:0]                    addr;
    logic                                        ap;
    logic                                        chop;
    logic [`DDRCD_BANKS-1:0]                     open;
    logic [`DDRCD_MR_NUM-1:0][`DDRCD_ADDR_W-1:0] mr;
    logic [2:0]                                  bcnt;
    logic [`DDRCD_BA_W-1:0]                      bbank;
    logic                                        bap;
    logic                                        zq_done;
    logic [9:0]                                  zcnt;
    logic                                        zq_init_win;
    logic [15:0]                                 ref_cnt;
  } ddrcd_dev_t;

  typedef struct packed {
    logic                     cke;
    logic                     cs_n;
    logic [2:0]               pins;
    logic [`DDRCD_BA_W-1:0]   ba;
    logic [`DDRCD_ADDR_W-1:0] addr;
    logic                     rstn;
    logic [2:0]               hold;
    logic                     rej;
  } ddrcd_host_t;

endpackage : ddrcd_pkg

// *** verilog/ddrcd_if.sv ***
// Command and address pins between controller and memory.
// All pins are driven by the controller end; the device samples all but ODT and takes RESET# as async reset.
`timescale 1ns/10ps
`include "ddrcd_defines.svh"

interface ddrcd_if;
  logic                     reset_n;
  logic                     cke;
  logic                     cs_n;
  logic                     ras_n;
  logic                     cas_n;
  logic                     we_n;
  logic                     odt;
  logic [`DDRCD_BA_W-1:0]   ba;
  logic [`DDRCD_ADDR_W-1:0] addr;

  modport dev (input reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
  modport ctl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr);
endinterface : ddrcd_if

// *** verilog/ddrcd_pin_decode.sv ***
// Pure pin decoder: turns sampled command pins and the CKE pair into one command.
// Assumes the caller samples the pins on the rising clock edge.
`timescale 1ns/10ps
`include "ddrcd_defines.svh"

module ddrcd_pin_decode
  import ddrcd_pkg::*;
(
  input  wire logic       cke_prev_in,
  input  wire logic       cke_in,
  input  wire logic       cs_n_in,
  input  wire logic [2:0] pins_in,
  input  wire logic       a10_in,
  output ddrcd_cmd_t      cmd_out
);

  logic idle_pins;

  // Deselect or no-operation on the pins
  assign idle_pins = cs_n_in || (pins_in == `DDRCD_PINS_NOP);

  // ==========================================================
  // Command selection
  always_comb begin
    cmd_out = DDRCD_CMD_BAD;
    if (!cke_prev_in) begin
      cmd_out = cke_in ? (idle_pins ? DDRCD_CMD_EXIT : DDRCD_CMD_BAD) : DDRCD_CMD_HOLD;
    end else if (!cke_in) begin
      if (idle_pins) begin
        cmd_out = DDRCD_CMD_PDE;
      end else if (pins_in == `DDRCD_PINS_REF) begin
        cmd_out = DDRCD_CMD_SRE;
      end
    end else if (cs_n_in) begin
      cmd_out = DDRCD_CMD_DES;
    end else begin
      unique case (pins_in)
        `DDRCD_PINS_MRS: cmd_out = DDRCD_CMD_MRS;
        `DDRCD_PINS_REF: cmd_out = DDRCD_CMD_REF;
        `DDRCD_PINS_PRE: cmd_out = a10_in ? DDRCD_CMD_PREA : DDRCD_CMD_PRE;
        `DDRCD_PINS_ACT: cmd_out = DDRCD_CMD_ACT;
        `DDRCD_PINS_WR:  cmd_out = DDRCD_CMD_WR;
        `DDRCD_PINS_RD:  cmd_out = DDRCD_CMD_RD;
        `DDRCD_PINS_ZQ:  cmd_out = a10_in ? DDRCD_CMD_ZQCL : DDRCD_CMD_ZQCS;
        `DDRCD_PINS_NOP: cmd_out = DDRCD_CMD_NOP;
      endcase
    end
  end

endmodule : ddrcd_pin_decode

// *** verilog/ddrcd_device.sv ***
// Memory-side command decoder: samples the command pins and tracks bank,
// burst, power and calibration state. Assumes pins are synchronous to clk_in.
//
// Behaviour
// - decode only from pins at rising edge
// - RESET# low resets asynchronously, else high
// - ODT never affects decoding
// - bank address selects bank or mode register
// - precharge with A10 low closes one bank
// - activate opens bank, address is row
// - write: column on low bits and A11
// - read: column on low bits and A11
// - A10 high adds auto-precharge after burst
// - started burst always completes
// - no-operation leaves work in progress alone
// - chip select high ignores other pins
// - CKE edges with idle pins enter/exit power-down
// - no own refresh while powered down
// - ZQ: A10 high long, low short
// - first long calibration uses initial window
// - controller issues no undefined combinations
// - controller holds CKE for minimum edges
`timescale 1ns/10ps
`include "ddrcd_defines.svh"

module ddrcd_device
  import ddrcd_pkg::*;
(
  input  wire logic                                        clk_in,
  input  wire logic                                        rst_in,
  input  wire logic                                        ce_in,
  ddrcd_if.dev                                             bus,
  output ddrcd_cmd_t                                       cmd_out,
  output logic                                             cmd_vld_out,
  output logic [`DDRCD_BA_W-1:0]                           bank_out,
  output logic [`DDRCD_ADDR_W-1:0]                         addr_out,
  output logic                                             auto_pre_out,
  output logic                                             chop_out,
  output ddrcd_state_t                                     state_out,
  output logic [`DDRCD_BANKS-1:0]                          open_banks_out,
  output logic                                             burst_busy_out,
  output logic                                             zq_busy_out,
  output logic                                             zq_init_win_out,
  output logic [`DDRCD_MR_NUM-1:0][`DDRCD_ADDR_W-1:0]      mode_regs_out,
  output logic [15:0]                                      ref_count_out
);

  ddrcd_dev_t s_ff;
  ddrcd_dev_t nxt_s;
  ddrcd_cmd_t dec_cmd;
  logic       rst_any;

  // ==========================================================
  // Burst choice from the mode register and A12
  function automatic logic burst_chop(input logic [`DDRCD_ADDR_W-1:0] mr0,
                                      input logic                     a12);
    logic [1:0] bl;
    bl = mr0[`DDRCD_MR0_BL_MSB:`DDRCD_MR0_BL_LSB];
    if (bl == `DDRCD_BL_OTF) begin
      burst_chop = !a12;
    end else begin
      burst_chop = (bl == `DDRCD_BL_FIX4);
    end
  endfunction : burst_chop

  // ==========================================================
  // Reset and pin decode
  // RESET# joins the async reset
  assign rst_any = rst_in || !bus.reset_n;

  // ODT is not wired into decode
  ddrcd_pin_decode u_decode (
    .cke_prev_in (s_ff.cke_prev),
    .cke_in      (bus.cke),
    .cs_n_in     (bus.cs_n),
    .pins_in     ({bus.ras_n, bus.cas_n, bus.we_n}),
    .a10_in      (bus.addr[`DDRCD_A10_POS]),
    .cmd_out     (dec_cmd)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.cke_prev = bus.cke;
    nxt_s.cmd      = dec_cmd;
    // strobe only with chip select low
    nxt_s.cmd_vld  = !bus.cs_n;

    // burst runs down regardless of new commands
    if (s_ff.bcnt != 3'h0) begin
      nxt_s.bcnt = s_ff.bcnt - 3'h1;
      if (s_ff.bcnt == 3'h1 && s_ff.bap) begin
        nxt_s.open[s_ff.bbank] = 1'b0;
      end
    end

    // Calibration window counts down
    if (s_ff.zcnt != 10'h000) begin
      nxt_s.zcnt = s_ff.zcnt - 10'h001;
    end

    unique case (dec_cmd)
      DDRCD_CMD_MRS: begin
        nxt_s.mr[bus.ba[1:0]] = bus.addr;
        nxt_s.ba              = bus.ba;
        nxt_s.addr            = bus.addr;
      end
      DDRCD_CMD_REF: begin
        if (s_ff.st != DDRCD_ST_PDN) begin
          nxt_s.ref_cnt = s_ff.ref_cnt + 16'h0001;
        end
      end
      DDRCD_CMD_SRE: begin
        nxt_s.st = DDRCD_ST_SREF;
      end
      DDRCD_CMD_PDE: begin
        nxt_s.st = DDRCD_ST_PDN;
      end
      DDRCD_CMD_EXIT: begin
        nxt_s.st = (s_ff.open != '0) ? DDRCD_ST_ACT : DDRCD_ST_IDLE;
      end
      DDRCD_CMD_PRE: begin
        nxt_s.open[bus.ba] = 1'b0;
        nxt_s.ba           = bus.ba;
      end
      DDRCD_CMD_PREA: begin
        nxt_s.open = '0;
      end
      DDRCD_CMD_ACT: begin
        nxt_s.open[bus.ba] = 1'b1;
        nxt_s.ba           = bus.ba;
        nxt_s.addr         = bus.addr;
      end
      DDRCD_CMD_WR,
      DDRCD_CMD_RD: begin
        // column from A11 and low bits
        nxt_s.ba   = bus.ba;
        nxt_s.addr = {{(`DDRCD_ADDR_W-11){1'b0}}, bus.addr[`DDRCD_A11_POS], bus.addr[9:0]};
        nxt_s.ap   = bus.addr[`DDRCD_A10_POS];
        nxt_s.chop = burst_chop(s_ff.mr[0], bus.addr[`DDRCD_A12_POS]);
        // a running burst is never cut short
        if (s_ff.bcnt == 3'h0) begin
          nxt_s.bcnt  = nxt_s.chop ? `DDRCD_BC4_CYC : `DDRCD_BL8_CYC;
          nxt_s.bbank = bus.ba;
          nxt_s.bap   = bus.addr[`DDRCD_A10_POS];
        end
      end
      DDRCD_CMD_ZQCL: begin
        nxt_s.zq_init_win = !s_ff.zq_done;
        nxt_s.zq_done     = 1'b1;
        nxt_s.zcnt        = s_ff.zq_done ? `DDRCD_ZQOPER_CYC : `DDRCD_ZQINIT_CYC;
      end
      DDRCD_CMD_ZQCS: begin
        nxt_s.zq_init_win = 1'b0;
        nxt_s.zcnt        = `DDRCD_ZQCS_CYC;
      end
      DDRCD_CMD_NOP,
      DDRCD_CMD_DES,
      DDRCD_CMD_HOLD,
      DDRCD_CMD_BAD: begin
        nxt_s.cmd = dec_cmd;
      end
    endcase

    // Awake state follows the open banks
    if (nxt_s.st == DDRCD_ST_IDLE || nxt_s.st == DDRCD_ST_ACT) begin
      nxt_s.st = (nxt_s.open != '0) ? DDRCD_ST_ACT : DDRCD_ST_IDLE;
    end
  end

  // ==========================================================
  // State register
  // everything is taken on the rising edge
  always_ff @(posedge clk_in or posedge rst_any) begin
    if (rst_any) begin
      s_ff <= '{st: DDRCD_ST_IDLE, cke_prev: 1'b0, cmd: DDRCD_CMD_HOLD,
                mr: {`DDRCD_MR_NUM{`DDRCD_MR_RST}}, default: '0};
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign cmd_out         = s_ff.cmd;
  assign cmd_vld_out     = s_ff.cmd_vld;
  assign bank_out        = s_ff.ba;
  assign addr_out        = s_ff.addr;
  assign auto_pre_out    = s_ff.ap;
  assign chop_out        = s_ff.chop;
  assign state_out       = s_ff.st;
  assign open_banks_out  = s_ff.open;
  assign burst_busy_out  = (s_ff.bcnt != 3'h0);
  assign zq_busy_out     = (s_ff.zcnt != 10'h000);
  assign zq_init_win_out = s_ff.zq_init_win;
  assign mode_regs_out   = s_ff.mr;
  assign ref_count_out   = s_ff.ref_cnt;

endmodule : ddrcd_device

// *** verilog/ddrcd_host.sv ***
// Controller end: turns user requests into registered pin levels.
// Assumes the user holds req_in until ready_out; commands illegal at the present CKE level are rejected.
`timescale 1ns/10ps
`include "ddrcd_defines.svh"

module ddrcd_host
  import ddrcd_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  input  wire logic                     req_in,
  input  ddrcd_cmd_t                    cmd_in,
  input  wire logic [`DDRCD_BA_W-1:0]   ba_in,
  input  wire logic [`DDRCD_ADDR_W-1:0] addr_in,
  output logic                          ready_out,
  output logic                          reject_out,
  ddrcd_if.ctl                          bus
);

  ddrcd_host_t h_ff;
  ddrcd_host_t nxt_h;
  logic        legal;
  logic        take;

  // ==========================================================
  // Legality against the present CKE level
  function automatic logic cmd_legal(input ddrcd_cmd_t c, input logic cke);
    unique case (c)
      DDRCD_CMD_EXIT: cmd_legal = !cke;
      DDRCD_CMD_HOLD,
      DDRCD_CMD_BAD:  cmd_legal = 1'b0;
      default:        cmd_legal = cke;
    endcase
  endfunction : cmd_legal

  // no request while CKE must hold
  assign ready_out = (h_ff.hold == 3'h0);
  assign legal     = cmd_legal(cmd_in, h_ff.cke);
  assign take      = req_in && ready_out;

  // ==========================================================
  // Next pin levels; idle pins are NOP between commands
  always_comb begin
    nxt_h      = h_ff;
    nxt_h.rstn = 1'b1;
    nxt_h.cs_n = 1'b0;
    nxt_h.pins = `DDRCD_PINS_NOP;
    nxt_h.rej  = 1'b0;
    if (h_ff.hold != 3'h0) begin
      nxt_h.hold = h_ff.hold - 3'h1;
    end
    if (take && !legal) begin
      nxt_h.rej = 1'b1;
    end else if (take) begin
      nxt_h.ba   = ba_in;
      nxt_h.addr = addr_in;
      unique case (cmd_in)
        DDRCD_CMD_MRS:  nxt_h.pins = `DDRCD_PINS_MRS;
        DDRCD_CMD_REF:  nxt_h.pins = `DDRCD_PINS_REF;
        DDRCD_CMD_PRE:  nxt_h.pins = `DDRCD_PINS_PRE;
        DDRCD_CMD_ACT:  nxt_h.pins = `DDRCD_PINS_ACT;
        DDRCD_CMD_WR:   nxt_h.pins = `DDRCD_PINS_WR;
        DDRCD_CMD_RD:   nxt_h.pins = `DDRCD_PINS_RD;
        DDRCD_CMD_ZQCS: nxt_h.pins = `DDRCD_PINS_ZQ;
        DDRCD_CMD_DES:  nxt_h.cs_n = 1'b1;
        DDRCD_CMD_PREA: begin
          nxt_h.pins                  = `DDRCD_PINS_PRE;
          nxt_h.addr[`DDRCD_A10_POS]  = 1'b1;
        end
        DDRCD_CMD_ZQCL: begin
          nxt_h.pins                  = `DDRCD_PINS_ZQ;
          nxt_h.addr[`DDRCD_A10_POS]  = 1'b1;
        end
        DDRCD_CMD_SRE: begin
          nxt_h.pins = `DDRCD_PINS_REF;
          nxt_h.cke  = 1'b0;
          nxt_h.hold = `DDRCD_TCKE_CYC;
        end
        DDRCD_CMD_PDE,
        DDRCD_CMD_EXIT: begin
          // CKE edge with NOP, then hold
          nxt_h.cke  = !h_ff.cke;
          nxt_h.hold = `DDRCD_TCKE_CYC;
        end
        default: nxt_h.pins = `DDRCD_PINS_NOP;
      endcase
    end
  end

  // ==========================================================
  // RESET# low in reset, high afterwards
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      h_ff <= '{cs_n: 1'b1, pins: `DDRCD_PINS_NOP, default: '0};
    end else if (ce_in) begin
      h_ff <= nxt_h;
    end
  end

  assign reject_out  = h_ff.rej;
  assign bus.reset_n = h_ff.rstn;
  assign bus.cke     = h_ff.cke;
  assign bus.cs_n    = h_ff.cs_n;
  assign bus.ras_n   = h_ff.pins[2];
  assign bus.cas_n   = h_ff.pins[1];
  assign bus.we_n    = h_ff.pins[0];
  assign bus.odt     = 1'b0;
  assign bus.ba      = h_ff.ba;
  assign bus.addr    = h_ff.addr;

endmodule : ddrcd_host

// *** sim/ddrcd_asserts.sv ***
// Assertions on the command pins and the decoder's answers.
// Assumes ce_in held high; placed beside the pin interface.
`timescale 1ns/10ps

module ddrcd_asserts
  import ddrcd_pkg::*;
(
  input logic         clk_in,
  input logic         rst_in,
  input logic         reset_n,
  input logic         cke,
  input logic         cs_n,
  input logic         ras_n,
  input logic         cas_n,
  input logic         we_n,
  input logic [2:0]   ba,
  input logic [13:0]  addr,
  input ddrcd_cmd_t   cmd_out,
  input logic         cmd_vld_out,
  input ddrcd_state_t state_out,
  input logic [7:0]   open_banks_out,
  input logic         burst_busy_out,
  input logic [15:0]  ref_count_out,
  input logic         ready_out
);
  // Strobe code and a selected, clock-enabled edge
  wire [2:0] pins = {ras_n, cas_n, we_n};
  wire       sel  = !cs_n && cke;

  // Device reset covers both reset inputs
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in || !reset_n);

  a_strobe_each_edge: assert property (!cs_n |=> cmd_vld_out)
    else $error("no strobe after selected edge");
  a_deselect_quiet: assert property (cs_n |=> !cmd_vld_out)
    else $error("strobe while deselected");
  a_refresh_count: assert property (sel && $past(cke) && pins == 3'h1 |=>
    cmd_out == DDRCD_CMD_REF && ref_count_out == $past(ref_count_out) + 16'h1)
    else $error("refresh not decoded or counted");
  a_self_ref_entry: assert property (!cs_n && !cke && $past(cke) && pins == 3'h1 |=>
    cmd_out == DDRCD_CMD_SRE && state_out == DDRCD_ST_SREF)
    else $error("self refresh not entered");
  a_one_bank_close: assert property (sel && $past(cke) && pins == 3'h2 && !addr[10] |=>
    cmd_out == DDRCD_CMD_PRE && !open_banks_out[$past(ba)])
    else $error("single bank not closed");
  a_all_bank_close: assert property (sel && $past(cke) && pins == 3'h2 && addr[10] |=>
    cmd_out == DDRCD_CMD_PREA && open_banks_out == 8'h00)
    else $error("banks left open after close all");
  a_bank_open: assert property (sel && $past(cke) && pins == 3'h3 |=>
    cmd_out == DDRCD_CMD_ACT && open_banks_out[$past(ba)])
    else $error("bank not opened");
  a_zq_select: assert property (sel && $past(cke) && pins == 3'h6 |=>
    cmd_out == ($past(addr[10]) ? DDRCD_CMD_ZQCL : DDRCD_CMD_ZQCS))
    else $error("wrong calibration kind");
  a_pdn_entry: assert property (!cke && $past(cke) && (cs_n || pins == 3'h7) |=>
    state_out == DDRCD_ST_PDN)
    else $error("power-down not entered");
  a_pdn_no_refresh: assert property (state_out == DDRCD_ST_PDN |=> $stable(ref_count_out))
    else $error("refresh counted in power-down");
  a_burst_length: assert property ($rose(burst_busy_out) |->
    burst_busy_out[*2] ##[1:3] !burst_busy_out)
    else $error("burst length out of range");
  a_cke_hold: assert property ($changed(cke) && $past(reset_n) |->
    !ready_out[*3] ##1 ready_out)
    else $error("clock enable hold wrong");

  // Main scenarios reached
  c_self_ref: cover property (state_out == DDRCD_ST_SREF);
  c_close_all: cover property (cmd_out == DDRCD_CMD_PREA);
  c_zq_long: cover property (cmd_out == DDRCD_CMD_ZQCL);
endmodule : ddrcd_asserts

// *** sim/tb_top.sv ***
// Bench of the command link: host and device joined by the pin interface.
// Assumes one 10 MHz clock; stimulus enters at the host user side only.
`timescale 1ns/10ps

module tb_top
  import ddrcd_pkg::*;
;
  logic             clk_in = 1'b0;
  logic             rst_in = 1'b1;
  logic             req_in = 1'b0;
  ddrcd_cmd_t       cmd_in = DDRCD_CMD_NOP;
  logic [2:0]       ba_in = 3'h0;
  logic [13:0]      addr_in = 14'h0000;
  ddrcd_cmd_t       cmd_out;
  ddrcd_state_t     state_out;
  logic             cmd_vld_out, auto_pre_out, chop_out, burst_busy_out;
  logic             zq_busy_out, zq_init_win_out, ready_out, reject_out;
  logic [2:0]       bank_out;
  logic [13:0]      addr_out;
  logic [7:0]       open_banks_out;
  logic [15:0]      ref_count_out;
  logic [3:0][13:0] mode_regs_out;
  int               num_errors = 0;
  int               checks_done = 0;
  int               cycles = 0;

  // ==========================================
  // Instances
  ddrcd_if bus_if ();
  ddrcd_host ddrcd_host_inst (.clk_in, .rst_in, .ce_in(1'b1), .req_in, .cmd_in, .ba_in,
    .addr_in, .ready_out, .reject_out, .bus(bus_if));
  ddrcd_device ddrcd_device_inst (.clk_in, .rst_in, .ce_in(1'b1), .bus(bus_if), .cmd_out,
    .cmd_vld_out, .bank_out, .addr_out, .auto_pre_out, .chop_out, .state_out, .open_banks_out,
    .burst_busy_out, .zq_busy_out, .zq_init_win_out, .mode_regs_out, .ref_count_out);
  ddrcd_asserts ddrcd_asserts_inst (.clk_in, .rst_in, .reset_n(bus_if.reset_n),
    .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
    .we_n(bus_if.we_n), .ba(bus_if.ba), .addr(bus_if.addr), .cmd_out, .cmd_vld_out,
    .state_out, .open_banks_out, .burst_busy_out, .ref_count_out, .ready_out);

  // Clock and hang guard; whole run needs about 960 cycles
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_len(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_len

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step

  // Hold the request until taken; waits out the clock enable hold
  task automatic issue(input ddrcd_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    for (int n = 0; n < 20 && ready_out !== 1'b1; n++) begin
      step();
    end
    req_in = 1'b1;
    cmd_in = c;
    ba_in = b;
    addr_in = a;
    step();
    req_in = 1'b0;
  endtask : issue

  // One more edge so the device has decoded the pins
  task automatic send(input ddrcd_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    issue(c, b, a);
    step();
  endtask : send

  // Samples a busy flag stays high: k=0 burst, k=1 calibration
  task automatic len(input bit k, output int n);
    n = 0;
    while ((k ? zq_busy_out : burst_busy_out) === 1'b1 && n < 600) begin
      n++;
      step();
    end
  endtask : len

  // ==========================================
  // Scenarios
  task automatic zq_one(input ddrcd_cmd_t c, input logic w, input int l);
    int n;
    send(c, 3'h0, 14'h0000);
    chk(cmd_out, c);
    chk(zq_init_win_out, w);
    len(1, n);
    chk_len(n, l);
  endtask : zq_one

  task automatic t_zq();
    zq_one(DDRCD_CMD_ZQCL, 1'b1, 512);
    zq_one(DDRCD_CMD_ZQCL, 1'b0, 256);
    zq_one(DDRCD_CMD_ZQCS, 1'b0, 64);
  endtask : t_zq

  task automatic t_mrs();
    send(DDRCD_CMD_MRS, 3'h3, 14'h1abc);
    chk(cmd_out, DDRCD_CMD_MRS);
    chk(mode_regs_out[3], 14'h1abc);
    send(DDRCD_CMD_MRS, 3'h0, 14'h0001);
    chk(mode_regs_out[0], 14'h0001);
  endtask : t_mrs

  task automatic t_bank();
    send(DDRCD_CMD_ACT, 3'h2, 14'h0123);
    chk(cmd_out, DDRCD_CMD_ACT);
    chk(bank_out, 3'h2);
    chk(addr_out, 14'h0123);
    chk(state_out, DDRCD_ST_ACT);
    send(DDRCD_CMD_ACT, 3'h5, 14'h3fff);
    chk(open_banks_out, 8'h24);
    send(DDRCD_CMD_PRE, 3'h2, 14'h0000);
    chk(open_banks_out, 8'h20);
    send(DDRCD_CMD_PREA, 3'h2, 14'h0000);
    chk(open_banks_out, 8'h00);
  endtask : t_bank

  task automatic t_power();
    send(DDRCD_CMD_REF, 3'h0, 14'h0000);
    chk(cmd_out, DDRCD_CMD_REF);
    chk(ref_count_out, 16'h0001);
    send(DDRCD_CMD_SRE, 3'h0, 14'h0000);
    chk(state_out, DDRCD_ST_SREF);
    chk(ref_count_out, 16'h0001);
    send(DDRCD_CMD_EXIT, 3'h0, 14'h0000);
    chk(cmd_out, DDRCD_CMD_EXIT);
    chk(state_out, DDRCD_ST_IDLE);
    send(DDRCD_CMD_PDE, 3'h0, 14'h0000);
    chk(state_out, DDRCD_ST_PDN);
    issue(DDRCD_CMD_REF, 3'h0, 14'h0000);
    chk(reject_out, 1'b1);
    step();
    chk(cmd_out, DDRCD_CMD_HOLD);
    chk(ref_count_out, 16'h0001);
    send(DDRCD_CMD_EXIT, 3'h0, 14'h0000);
    chk(state_out, DDRCD_ST_IDLE);
    send(DDRCD_CMD_DES, 3'h7, 14'h3fff);
    chk(cmd_vld_out, 1'b0);
    chk(cmd_out, DDRCD_CMD_DES);
    step();
    chk(cmd_out, DDRCD_CMD_NOP);
  endtask : t_power

  task automatic t_burst();
    int n;
    send(DDRCD_CMD_ACT, 3'h1, 14'h0042);
    // on-the-fly chop, A11 set, A10 clear
    for (int i = 0; i < 4; i++) begin
      send(i[0] ? DDRCD_CMD_WR : DDRCD_CMD_RD, 3'h1, {1'b0, i[1], 12'h8a5});
      chk(cmd_out, i[0] ? DDRCD_CMD_WR : DDRCD_CMD_RD);
      chk(addr_out, 14'h04a5);
      chk(chop_out, !i[1]);
      len(0, n);
      chk_len(n, i[1] ? 4 : 2);
    end
    send(DDRCD_CMD_RD, 3'h1, 14'h1400);
    chk(auto_pre_out, 1'b1);
    len(0, n);
    chk(open_banks_out, 8'h00);
    for (int i = 0; i < 2; i++) begin
      send(DDRCD_CMD_ACT, 3'h1, 14'h0042);
      send(DDRCD_CMD_WR, 3'h1, 14'h1000);
      send(i ? DDRCD_CMD_RD : DDRCD_CMD_NOP, 3'h1, 14'h1000);
      chk(cmd_out, i ? DDRCD_CMD_RD : DDRCD_CMD_NOP);
      len(0, n);
      chk_len(n, 2);
    end
    // Fixed settings ignore A12
    for (int i = 0; i < 2; i++) begin
      send(DDRCD_CMD_MRS, 3'h0, i ? 14'h0002 : 14'h0000);
      send(DDRCD_CMD_RD, 3'h1, i ? 14'h1000 : 14'h0000);
      chk(chop_out, i[0]);
      len(0, n);
      chk_len(n, i ? 2 : 4);
    end
  endtask : t_burst

  // ==========================================
  // Main sequence and verdict
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    step();
    chk(state_out, DDRCD_ST_IDLE);
    // CKE leaves reset low, so raise it before any command
    send(DDRCD_CMD_EXIT, 3'h0, 14'h0000);
    chk(cmd_out, DDRCD_CMD_EXIT);
    t_zq();
    t_mrs();
    t_bank();
    t_power();
    t_burst();
    end_of_test();
  end
endmodule : tb_top
